/* rtl/flash_protection.sv */
/*
 * Protection controller of the flash subsystem: debug interface lock,
 * global program/data flash read protection with inherited write
 * protection, and password-checked disable commands with an unchecked resume command,
 * all reached over an AXI4-Lite slave.
 * Assumes configuration block contents arrive on the flash clock and
 * stay stable once cfg_valid is high; exclusive protection comes from
 * a separate unit.
 */
// How it works
// - The debug interface is locked while its lock bit is set and unlocks only on a matching 256-bit password.
// - Program flash read protection is on when its configured read-protect bit is 1.
// - Data flash read protection is on when its configured read-protect bit is 1.
// - Active read protection of program flash or data flash bank 0 also blocks every write to that array or bank.
// - Program and data flash protection are enabled independently of each other.
// - Enabled read protection always drives the startup hardening, whatever the boot source.
// - Processor reads of protected flash are blocked only when the device did not boot internally.
// - The disable command with the right password lifts the inherited write protection.
// - One program flash password, not the debug one, lifts program flash read and write protection together.
// - Lifting program flash read protection lifts its write protection in the same cycle.
// - A dedicated password lifts read and write protection of data flash bank 0 together.
// - Data flash bank 1 and security sectors follow exclusive protection, not these passwords.
// - A lifted protection lasts until reset or the resume command, then is active again.
module flash_protection
   import flash_prot_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // configuration block contents from the flash subsystem
   input wire logic cfg_valid,
   input wire logic debug_interface_lock_bit,
   input wire logic [PW_W-1:0] debug_password,
   input wire logic program_flash_read_protect,
   input wire logic [PW_W-1:0] program_flash_password,
   input wire logic data_flash_read_protect,
   input wire logic [PW_W-1:0] data_flash_password,
   input wire logic boot_internal,
   input wire logic excl_prot_df1,
   input wire logic excl_prot_secure,
   // protection outputs
   output logic access_granted,
   output logic debug_if_locked,
   output logic startup_pf_protect,
   output logic startup_df_protect,
   output logic pf_cpu_read_block,
   output logic df0_cpu_read_block,
   output logic pf_write_block,
   output logic df0_write_block,
   output logic df1_access_block,
   output logic secure_sector_block
);

   typedef struct packed {
      prot_state_e state;
      logic loaded;
      logic dbg_lock_cfg;
      logic pf_rp_cfg;
      logic df_rp_cfg;
      logic boot_int;
      logic dbg_unlocked;
      logic pf_disabled;
      logic df_disabled;
      logic cmd_fail;
      logic [7:0] cmd;
      logic [PW_W-1:0] pw;
      logic aw_got;
      logic [ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [DATA_W-1:0] wdata;
      logic [STRB_W-1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } prot_state_s;

   prot_state_s s_reg;
   prot_state_s s_next;

   logic [PW_W-1:0] pw_expected;
   logic pw_match;
   logic pf_prot_on;
   logic df_prot_on;
   logic [DATA_W-1:0] status_word;

   always_comb begin
      unique case (s_reg.cmd)
         CMD_DISABLE_PF: pw_expected = program_flash_password;
         CMD_DISABLE_DF: pw_expected = data_flash_password;
         CMD_DBG_UNLOCK: pw_expected = debug_password;
         default: pw_expected = ~s_reg.pw;
      endcase
   end

   pw_compare #(
      .W(PW_W)
   ) u_pw_compare (
      .clk_sys(clk_sys),
      .rst(rst),
      .entered(s_reg.pw),
      .expected(pw_expected),
      .match_reg(pw_match)
   );

   assign pf_prot_on = !s_reg.loaded || (s_reg.pf_rp_cfg && !s_reg.pf_disabled);
   assign df_prot_on = !s_reg.loaded || (s_reg.df_rp_cfg && !s_reg.df_disabled);

   always_comb begin
      status_word = ZERO_WORD;
      status_word[ST_LOADED] = s_reg.loaded;
      status_word[ST_DBG_LOCKED] = debug_if_locked;
      status_word[ST_PF_RP_CFG] = s_reg.pf_rp_cfg;
      status_word[ST_DF_RP_CFG] = s_reg.df_rp_cfg;
      status_word[ST_PF_DISABLED] = s_reg.pf_disabled;
      status_word[ST_DF_DISABLED] = s_reg.df_disabled;
      status_word[ST_BOOT_INTERNAL] = s_reg.boot_int;
      status_word[ST_BUSY] = (s_reg.state != ST_READY);
      status_word[ST_CMD_FAIL] = s_reg.cmd_fail;
      status_word[ST_DBG_LOCK_CFG] = s_reg.dbg_lock_cfg;
   end

   always_comb begin
      logic do_write;
      logic [PW_IDX_W-1:0] pw_idx;
      logic fail_set;
      do_write = 1'b0;
      pw_idx = '0;
      fail_set = 1'b0;
      s_next = s_reg;

      // write channels are taken independently, in either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_next.aw_got = 1'b1;
         s_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_next.w_got = 1'b1;
         s_next.wdata = s_axi_wdata;
         s_next.wstrb = s_axi_wstrb;
      end
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
         do_write = 1'b1;
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = RESP_OKAY;
      end

      if (do_write) begin
         pw_idx = s_reg.aw_addr[PW_IDX_W+1:2];
         if (s_reg.aw_addr == OFF_STATUS) begin
            // failure flag is write-one-to-clear
            if (s_reg.wstrb[1] && s_reg.wdata[ST_CMD_FAIL]) begin
               s_next.cmd_fail = 1'b0;
            end
         end else if (s_reg.aw_addr == OFF_COMMAND) begin
            // busy or not yet loaded: command refused with an error answer
            if (s_reg.state != ST_READY || !s_reg.wstrb[0]) begin
               s_next.bresp = RESP_SLVERR;
            end else begin
               s_next.cmd = s_reg.wdata[7:0];
               unique case (s_reg.wdata[7:0])
                  CMD_DISABLE_PF, CMD_DISABLE_DF, CMD_DBG_UNLOCK: begin
                     s_next.state = ST_CHECK;
                  end
                  CMD_RESUME: begin
                     s_next.pf_disabled = 1'b0;
                     s_next.df_disabled = 1'b0;
                     s_next.dbg_unlocked = 1'b0;
                     s_next.pw = '0;
                  end
                  default: begin
                     fail_set = 1'b1;
                  end
               endcase
            end
         end else if ((s_reg.aw_addr & PW_REGION_MASK) == OFF_PW_BASE
                      && s_reg.aw_addr[1:0] == 2'h0) begin
            if (s_reg.state == ST_READY) begin
               for (int b = 0; b < STRB_W; b++) begin
                  if (s_reg.wstrb[b]) begin
                     s_next.pw[pw_idx*DATA_W + b*8 +: 8] = s_reg.wdata[b*8 +: 8];
                  end
               end
            end else begin
               s_next.bresp = RESP_SLVERR;
            end
         end else begin
            s_next.bresp = RESP_SLVERR;
         end
      end

      // read channel; password words read as zero so they never leak
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_next.rvalid = 1'b1;
         s_next.rresp = RESP_OKAY;
         s_next.rdata = ZERO_WORD;
         if (s_axi_araddr == OFF_STATUS) begin
            s_next.rdata = status_word;
         end else if (s_axi_araddr == OFF_COMMAND) begin
            s_next.rdata = {24'h00_0000, s_reg.cmd};
         end else if (!((s_axi_araddr & PW_REGION_MASK) == OFF_PW_BASE
                        && s_axi_araddr[1:0] == 2'h0)) begin
            s_next.rresp = RESP_SLVERR;
         end
      end

      unique case (s_reg.state)
         ST_LOAD: begin
            if (cfg_valid) begin
               s_next.loaded = 1'b1;
               s_next.dbg_lock_cfg = debug_interface_lock_bit;
               s_next.pf_rp_cfg = program_flash_read_protect;
               s_next.df_rp_cfg = data_flash_read_protect;
               s_next.boot_int = boot_internal;
               s_next.state = ST_READY;
            end
         end
         ST_READY: begin
         end
         // comparator result is registered, so one cycle to settle
         ST_CHECK: begin
            s_next.state = ST_APPLY;
         end
         ST_APPLY: begin
            s_next.state = ST_READY;
            s_next.pw = '0;
            if (!pw_match) begin
               fail_set = 1'b1;
            end else begin
               unique case (s_reg.cmd)
                  CMD_DISABLE_PF: s_next.pf_disabled = 1'b1;
                  CMD_DISABLE_DF: s_next.df_disabled = 1'b1;
                  CMD_DBG_UNLOCK: s_next.dbg_unlocked = 1'b1;
                  default: fail_set = 1'b1;
               endcase
            end
         end
      endcase

      // a failure in the same cycle as its clear wins
      if (fail_set) begin
         s_next.cmd_fail = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.state <= ST_LOAD;
      end else begin
         s_reg <= s_next;
      end
   end

   assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
   assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_arready = !s_reg.rvalid;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;

   assign access_granted = s_reg.loaded;
   // debug lock from the configured bit
   assign debug_if_locked = !s_reg.loaded || (s_reg.dbg_lock_cfg && !s_reg.dbg_unlocked);
   assign startup_pf_protect = pf_prot_on;
   assign startup_df_protect = df_prot_on;
   // cpu reads only blocked on external boot
   assign pf_cpu_read_block = !s_reg.loaded || (pf_prot_on && !s_reg.boot_int);
   assign df0_cpu_read_block = !s_reg.loaded || (df_prot_on && !s_reg.boot_int);
   assign pf_write_block = pf_prot_on;
   assign df0_write_block = df_prot_on;
   assign df1_access_block = !s_reg.loaded || excl_prot_df1;
   assign secure_sector_block = !s_reg.loaded || excl_prot_secure;

endmodule

/* include/flash_prot_pkg.sv */
/*
 * Shared constants and types of the flash read/write protection block:
 * register offsets, status bit positions, command codes, responses, states.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package flash_prot_pkg;

   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int STRB_W = DATA_W / 8;

   // password width and the number of bus words that carry it
   localparam int PW_W = 256;
   localparam int PW_WORDS = PW_W / DATA_W;
   localparam int PW_IDX_W = 3;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_COMMAND = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_PW_BASE = 8'h20;
   localparam logic [ADDR_W-1:0] PW_REGION_MASK = 8'hE0;

   // status register bit positions
   localparam int ST_LOADED = 0;
   localparam int ST_DBG_LOCKED = 1;
   localparam int ST_PF_RP_CFG = 2;
   localparam int ST_DF_RP_CFG = 3;
   localparam int ST_PF_DISABLED = 4;
   localparam int ST_DF_DISABLED = 5;
   localparam int ST_BOOT_INTERNAL = 6;
   localparam int ST_BUSY = 7;
   localparam int ST_CMD_FAIL = 8;
   localparam int ST_DBG_LOCK_CFG = 9;

   // command codes, written to the low byte of the command register
   localparam logic [7:0] CMD_NONE = 8'h00;
   localparam logic [7:0] CMD_DISABLE_PF = 8'h01;
   localparam logic [7:0] CMD_DISABLE_DF = 8'h02;
   localparam logic [7:0] CMD_RESUME = 8'h03;
   localparam logic [7:0] CMD_DBG_UNLOCK = 8'h04;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_LOAD,
      ST_READY,
      ST_CHECK,
      ST_APPLY
   } prot_state_e;

endpackage

/* rtl/pw_compare.sv */
/*
 * Registered comparison of an entered password against a reference.
 * Assumes both inputs are stable for the cycle before the result is used.
 */
module pw_compare
   import flash_prot_pkg::*;
#(
   parameter int W = PW_W
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [W-1:0] entered,
   input wire logic [W-1:0] expected,
   output logic match_reg
);

   typedef struct packed {
      logic match;
   } cmp_state_s;

   cmp_state_s s_reg;
   cmp_state_s s_next;

   // full-width compare; a partial match never counts
   always_comb begin
      s_next = s_reg;
      s_next.match = (entered == expected);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign match_reg = s_reg.match;

endmodule

/* testbench/flash_cfg_model.sv */
/*
 * Configuration block source: presents stored protection bits and
 * raises cfg_valid a programmable number of cycles after reset.
 * Assumes mode and dly change only while rst is high.
 */
module flash_cfg_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [3:0] mode,
   input wire logic [3:0] dly,
   output logic cfg_valid,
   output logic lock_bit,
   output logic pf_rp,
   output logic df_rp,
   output logic boot_int
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_reg;
   // a slow block read is modelled by a larger dly
   always_ff @(posedge clk_sys) begin
      if (rst)
         cnt_reg <= 4'h0;
      else if (cnt_reg != dly)
         cnt_reg <= cnt_reg + 4'h1;
   end
   assign cfg_valid = !rst && cnt_reg == dly;
   assign lock_bit = mode[0];
   assign pf_rp = mode[1];
   assign df_rp = mode[2];
   assign boot_int = mode[3];
endmodule

/* testbench/flash_protection_checker.sv */
/*
 * Port-level properties of flash_protection.
 * Assumes configuration inputs change only while rst is high.
 */
module flash_protection_checker
   import flash_prot_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic debug_interface_lock_bit,
   input wire logic program_flash_read_protect,
   input wire logic data_flash_read_protect,
   input wire logic boot_internal,
   input wire logic excl_prot_df1,
   input wire logic access_granted,
   input wire logic debug_if_locked,
   input wire logic startup_pf_protect,
   input wire logic startup_df_protect,
   input wire logic pf_cpu_read_block,
   input wire logic df0_cpu_read_block,
   input wire logic pf_write_block,
   input wire logic df0_write_block,
   input wire logic df1_access_block,
   input wire logic secure_sector_block
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_unloaded_block:
   assert property (!access_granted |-> debug_if_locked && pf_write_block && df0_write_block
      && pf_cpu_read_block && df0_cpu_read_block && df1_access_block && secure_sector_block)
      else $error("access open before load");
   a_pf_write_tie:
   assert property (pf_write_block == startup_pf_protect) else $error("pf write differs");
   a_df_write_tie:
   assert property (df0_write_block == startup_df_protect) else $error("df write differs");
   a_pf_read_inside:
   assert property (pf_cpu_read_block |-> pf_write_block) else $error("pf read block alone");
   a_boot_read_open:
   assert property (access_granted && boot_internal |-> !pf_cpu_read_block
      && !df0_cpu_read_block) else $error("read blocked on internal boot");
   a_lock_cfg_off:
   assert property (access_granted && !debug_interface_lock_bit |-> !debug_if_locked)
      else $error("debug locked without lock bit");
   a_pf_cfg_off:
   assert property (access_granted && !program_flash_read_protect |-> !pf_write_block)
      else $error("pf blocked without read protect");
   a_df_cfg_off:
   assert property (access_granted && !data_flash_read_protect |-> !df0_write_block)
      else $error("df blocked without read protect");
   a_df1_pass:
   assert property (df1_access_block == (!access_granted || excl_prot_df1))
      else $error("df1 block wrong");
   a_bresp_hold:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   cover property (access_granted && !pf_write_block);
   cover property (access_granted && debug_interface_lock_bit && !debug_if_locked);
   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind flash_protection flash_protection_checker u_flash_protection_checker (
   .clk_sys, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .debug_interface_lock_bit,
   .program_flash_read_protect, .data_flash_read_protect, .boot_internal, .excl_prot_df1,
   .access_granted, .debug_if_locked, .startup_pf_protect, .startup_df_protect,
   .pf_cpu_read_block, .df0_cpu_read_block, .pf_write_block, .df0_write_block,
   .df1_access_block, .secure_sector_block);

/* testbench/flash_protection_bench.sv */
/*
 * Self-checking bench of flash_protection over AXI4-Lite.
 * Assumes the configuration source model beside the design.
 */
module flash_protection_bench
   import flash_prot_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   function automatic logic [PW_W-1:0] mkpw(input logic [7:0] b);
      for (int k = 0; k < PW_WORDS; k++)
         mkpw[32*k+:32] = {b, 16'h5A00, 8'(k)};
   endfunction
   localparam logic [PW_W-1:0] PF_PW = mkpw(8'hC1);
   localparam logic [PW_W-1:0] DF_PW = mkpw(8'hD2);
   localparam logic [PW_W-1:0] DBG_PW = mkpw(8'hE3);
   logic clk_sys;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [DATA_W-1:0] s_axi_wdata = ZERO_WORD, s_axi_rdata, q;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [3:0] mode = 4'h7, dly = 4'h0;
   logic [STRB_W-1:0] s_axi_wstrb = 4'hF;
   logic excl_df1 = 1'b0, excl_sec = 1'b0;
   logic cfg_valid, lock_bit, pf_rp, df_rp, boot_int;
   logic acc, dbg_lk, st_pf, st_df, pf_rd, df_rd, pf_wr, df_wr, df1_blk, sec_blk;
   int n_mismatch = 0;
   int comparisons = 0;
   flash_cfg_model u_flash_cfg_model (.clk_sys, .rst, .mode, .dly, .cfg_valid, .lock_bit,
      .pf_rp, .df_rp, .boot_int);
   flash_protection u_flash_protection (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_valid,
      .debug_interface_lock_bit(lock_bit), .debug_password(DBG_PW),
      .program_flash_read_protect(pf_rp), .program_flash_password(PF_PW),
      .data_flash_read_protect(df_rp), .data_flash_password(DF_PW), .boot_internal(boot_int),
      .excl_prot_df1(excl_df1), .excl_prot_secure(excl_sec), .access_granted(acc),
      .debug_if_locked(dbg_lk), .startup_pf_protect(st_pf), .startup_df_protect(st_df),
      .pf_cpu_read_block(pf_rd), .df0_cpu_read_block(df_rd), .pf_write_block(pf_wr),
      .df0_write_block(df_wr), .df1_access_block(df1_blk), .secure_sector_block(sec_blk));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic wrap_up();
      if (n_mismatch == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input bit w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      bit ta, tw, ka, kw;
      int n;
      ta = 1'b0;
      tw = !w;
      n = 0;
      r = 2'h3;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      while (!(ta && tw) && n < 50) begin
         @(negedge clk_sys);
         ka = !ta && (w ? s_axi_awready : s_axi_arready) === 1'b1;
         kw = !tw && s_axi_wready === 1'b1;
         @(posedge clk_sys);
         if (ka) s_axi_awvalid <= 1'b0;
         if (ka) s_axi_arvalid <= 1'b0;
         if (kw) s_axi_wvalid <= 1'b0;
         ta |= ka;
         tw |= kw;
         n++;
      end
      while (r === 2'h3 && n < 99) begin
         @(negedge clk_sys);
         if (w && s_axi_bvalid === 1'b1) r = s_axi_bresp;
         if (!w && s_axi_rvalid === 1'b1) r = s_axi_rresp;
         q = s_axi_rdata;
         @(posedge clk_sys);
         n++;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (n >= 99) n_mismatch++;
   endtask
   // password words first, then the code; poll until the check is over
   task automatic cmd(input logic [7:0] c, input logic [PW_W-1:0] p);
      for (int k = 0; k < PW_WORDS; k++)
         bus(1'b1, OFF_PW_BASE + 8'(4 * k), p[32*k+:32]);
      bus(1'b1, OFF_COMMAND, {24'h00_0000, c});
      q = 32'h0000_0080;
      for (int k = 0; k < 20 && q[ST_BUSY] !== 1'b0; k++)
         bus(1'b0, OFF_STATUS, ZERO_WORD);
      @(negedge clk_sys);
   endtask
   task automatic do_reset(input logic [3:0] m, input logic [3:0] dl);
      @(posedge clk_sys);
      rst <= 1'b1;
      mode <= m;
      dly <= dl;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
   endtask
   task automatic wait_load();
      for (int k = 0; k < 30 && acc !== 1'b1; k++)
         @(negedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic t_unloaded();
      do_reset(4'h7, 4'h9);
      @(negedge clk_sys);
      chk("blocked", 32'({acc, dbg_lk, st_pf, st_df, pf_rd, df_rd, pf_wr, df_wr, df1_blk,
         sec_blk}), 32'h0000_01FF);
      bus(1'b1, OFF_COMMAND, 32'(CMD_DISABLE_PF));
      chk("early cmd", 32'(r), 32'(RESP_SLVERR));
      wait_load();
      chk("granted", 32'(acc), 32'h1);
   endtask
   task automatic t_combos();
      for (int i = 0; i < 16; i++) begin
         do_reset(4'(i), 4'h0);
         wait_load();
         chk("lock", 32'(dbg_lk), 32'(i[0]));
         chk("pf", 32'({st_pf, pf_wr}), 32'({2{i[1]}}));
         chk("df", 32'({st_df, df_wr}), 32'({2{i[2]}}));
         chk("cpu read", 32'({pf_rd, df_rd}), 32'({i[1] & !i[3], i[2] & !i[3]}));
         bus(1'b0, OFF_STATUS, ZERO_WORD);
         chk("status", q, 32'({i[0], 2'h0, i[3], 2'h0, i[2:0], 1'b1}));
      end
   endtask
   task automatic t_commands();
      excl_df1 <= 1'b1;
      // debug lock paired with read protection
      do_reset(4'h7, 4'h0);
      wait_load();
      cmd(CMD_DISABLE_PF, PF_PW);
      chk("pf off", 32'({pf_wr, st_pf, pf_rd}), 32'h0);
      chk("others", 32'({df_wr, dbg_lk}), 32'h3);
      cmd(CMD_DISABLE_DF, DBG_PW);
      chk("df wrong pw", 32'({q[ST_CMD_FAIL], df_wr}), 32'h3);
      bus(1'b1, OFF_STATUS, 32'h0000_0100);
      cmd(CMD_DISABLE_DF, DF_PW);
      chk("df lifted", 32'({q[ST_CMD_FAIL], q[ST_DF_DISABLED], df_wr, df_rd, df1_blk, sec_blk}),
         32'h12);
      @(posedge clk_sys);
      excl_df1 <= 1'b0;
      excl_sec <= 1'b1;
      @(negedge clk_sys);
      chk("exclusive", 32'({df1_blk, sec_blk}), 32'h1);
      cmd(CMD_DBG_UNLOCK, PF_PW);
      chk("dbg wrong pw", 32'({q[ST_CMD_FAIL], dbg_lk}), 32'h3);
      bus(1'b1, OFF_STATUS, 32'h0000_0100);
      cmd(CMD_DBG_UNLOCK, DBG_PW);
      chk("dbg open", 32'(dbg_lk), 32'h0);
      // a command without its low byte strobe is refused and changes nothing
      @(posedge clk_sys);
      s_axi_wstrb <= 4'hE;
      bus(1'b1, OFF_COMMAND, 32'(CMD_RESUME));
      s_axi_wstrb <= 4'hF;
      chk("strobe", 32'({r, pf_wr, dbg_lk}), 32'h8);
      cmd(CMD_RESUME, {PW_W{1'b0}});
      chk("resumed", 32'({dbg_lk, pf_wr, df_wr, pf_rd}), 32'hF);
      cmd(8'h07, PF_PW);
      chk("bad code", 32'({q[ST_CMD_FAIL], pf_wr}), 32'h3);
      cmd(CMD_DISABLE_PF, PF_PW);
      chk("pf again", 32'(pf_wr), 32'h0);
      do_reset(4'h7, 4'h0);
      wait_load();
      chk("reset restores", 32'({pf_wr, pf_rd}), 32'h3);
      bus(1'b0, 8'h10, ZERO_WORD);
      chk("unmapped", {q[29:0], r}, 32'(RESP_SLVERR));
   endtask
   initial begin
      t_unloaded();
      t_combos();
      t_commands();
      wrap_up();
   end
   // run takes about six hundred cycles
   initial begin
      #100000;
      n_mismatch++;
      wrap_up();
   end
endmodule
